// ---- psp_pkg.sv ----
package psp_pkg;

	// ==============================
	// Sizes
	localparam int NUM_HB = 4;
	localparam int NUM_HS = 3;
	localparam int ADDR_W = 8;

	// ==============================
	// Register indices, byte address is index times four
	localparam int          IDX_LSB         = 2;
	localparam int          IDX_W           = 4;
	localparam logic [3:0]  IDX_SYS_CTRL    = 4'h0;
	localparam logic [3:0]  IDX_BRIDGE_SEL  = 4'h1;
	localparam logic [3:0]  IDX_HS_OUT      = 4'h2;
	localparam logic [3:0]  IDX_BRIDGE_STAT = 4'h3;
	localparam logic [3:0]  IDX_HS_STAT     = 4'h4;
	localparam logic [3:0]  IDX_IRQ_FLAG    = 4'h8;
	localparam logic [3:0]  IDX_IRQ_MASK    = 4'h9;
	localparam logic [3:0]  IDX_AMUX        = 4'hA;

	// ==============================
	// Field positions
	localparam int SYS_STG_EN = 0;
	localparam int SYS_V_INH  = 1;
	localparam int SYS_HOT_SD = 2;
	localparam int HSO_PWM    = 3;
	localparam int BST_RECIRC = 7;
	localparam int IRQ_HOT    = 0;
	localparam int IRQ_UV     = 1;
	localparam int IRQ_OV     = 2;
	localparam int AMUX_GAIN  = 0;

	// ==============================
	// Bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==============================
	// Carriers
	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} psp_axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} psp_axil_rsp_t;

	typedef struct packed {
		logic [NUM_HB-1:0] hb_oc_hs;
		logic [NUM_HB-1:0] hb_oc_ls;
		logic [NUM_HS-1:0] hs_oc;
		logic              temp_hot;
		logic              temp_reset;
		logic              low_volt;
		logic              high_volt;
		logic              pwm;
	} psp_sense_t;

	typedef struct packed {
		logic [NUM_HB-1:0] hb_hs;
		logic [NUM_HB-1:0] hb_ls;
		logic [NUM_HS-1:0] hs;
		logic              aux_off;
	} psp_gate_t;

endpackage

// ---- psp_sync2.sv ----
`timescale 1ns/1ps
`default_nettype none
module psp_sync2 import psp_pkg::*; #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Data
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule
`default_nettype wire

// ---- psp_hb_leg.sv ----
`timescale 1ns/1ps
`default_nettype none
module psp_hb_leg import psp_pkg::*; (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Control
	input  wire logic sel_l,
	input  wire logic sel_h,
	input  wire logic recirc,
	input  wire logic pwm,
	input  wire logic flag_clr,
	input  wire logic hs_block,
	input  wire logic all_block,
	// Detectors
	input  wire logic oc_hs,
	input  wire logic oc_ls,
	// Results
	output var  logic flag_r,
	output var  logic hs_gate_r,
	output var  logic ls_gate_r
);
	logic hs_trip_r;
	logic ls_trip_r;
	logic flag_nxt;
	logic hs_trip_nxt;
	logic ls_trip_nxt;
	logic pwm_mode;
	logic hs_want;
	logic ls_want;
	logic hs_nxt;
	logic ls_nxt;

	// ==============================
	// Latches, a new trip beats a clear in the same cycle
	assign flag_nxt    = oc_hs | oc_ls | (flag_r & ~flag_clr);
	assign hs_trip_nxt = oc_hs | (hs_trip_r & ~flag_clr);
	assign ls_trip_nxt = oc_ls | (ls_trip_r & ~flag_clr);

	// ==============================
	// Select decode
	assign pwm_mode = sel_l & sel_h;
	assign hs_want  = pwm_mode ? pwm : (sel_h & ~sel_l);
	assign ls_want  = pwm_mode ? (recirc & ~pwm) : (sel_l & ~sel_h);
	assign hs_nxt   = hs_want & ~hs_trip_nxt & ~hs_block & ~all_block;
	assign ls_nxt   = ls_want & ~ls_trip_nxt & ~all_block;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flag_r    <= 1'h0;
			hs_trip_r <= 1'h0;
			ls_trip_r <= 1'h0;
			hs_gate_r <= 1'h0;
			ls_gate_r <= 1'h0;
		end else begin
			flag_r    <= flag_nxt;
			hs_trip_r <= hs_trip_nxt;
			ls_trip_r <= ls_trip_nxt;
			hs_gate_r <= hs_nxt;
			ls_gate_r <= ls_nxt;
		end
	end

	// ==============================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_leg_oc_trip: assert property (
		oc_hs |=> flag_r && !hs_gate_r && hs_trip_r)
		else $error("high side over-current not latched");
	a_leg_ls_trip: assert property (
		oc_ls |=> flag_r && !ls_gate_r)
		else $error("low side over-current not latched");
	a_leg_recirc: assert property (
		pwm_mode && recirc && !pwm && !all_block && !ls_trip_nxt |=> ls_gate_r)
		else $error("recirculation low side not on");
	a_leg_no_shoot: assert property (
		!(hs_gate_r && ls_gate_r))
		else $error("both transistors on");
endmodule
`default_nettype wire

// ---- psp_ctrl.sv ----
// How it works
// - Sense gain bit 1 selects low resolution, 0 selects high resolution.
// - First temperature threshold sets hot flag; interrupt only while mask set.
// - Hot shutdown select decides whether hot flag switches stages off.
// - Hot shutdown turns off all high sides and bridge high transistors.
// - Writing 1 clears hot flag unless temperature still high; reset clears.
// - Without hot shutdown, second threshold turns every power stage off.
// - Bridge over-current switches off the affected transistor and sets flag.
// - Writing 1 clears bridge over-current flag and re-enables; 0 does nothing.
// - Voltage flag with inhibit clear disables the half-bridge outputs.
// - Writing 1 clears voltage flag unless fault still present; reset clears.
// - Recirculation bit 1 uses low transistor, 0 the diode; reset clears.
// - High sides run only while the power stage enable bit is set.
// - Mode off/on; in on mode over-current turns off and flags.
// - PWM mode follows input; over-current off until next rising edge.
// - Both bits set: on, current limit sets flag without disabling.
// - Voltage flag with inhibit clear disables the high side outputs.
// - Both bridge select bits set: high transistor follows PWM input.
// - PWM mode with recirculation: low transistor on while high is off.
// - Writing 1 clears high side over-current flag and re-enables driver.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module psp_ctrl import psp_pkg::*; (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          rst,
	// Register bus
	input  wire psp_axil_req_t bus_req,
	output var  psp_axil_rsp_t bus_rsp,
	// Detectors and PWM pin
	input  wire psp_sense_t    sense_in,
	// Power stage drive
	output var  psp_gate_t     gate_out,
	output var  logic          hot_irq,
	output var  logic          sense_gain_low
);
	// ==============================
	// Declarations
	psp_sense_t        s;
	logic              pwm_d_r;
	logic              pwm_rise;
	logic [3:0]        sys_r;
	logic [7:0]        bsel_r;
	logic [5:0]        hso_r;
	logic              recirc_r;
	logic              hot_mask_r;
	logic              gain_r;
	logic              hot_flag_r;
	logic              uv_r;
	logic              ov_r;
	logic [NUM_HS-1:0] hs_flag_r;
	logic [NUM_HS-1:0] hs_trip_r;
	logic [NUM_HS-1:0] hs_gate_r;
	logic [NUM_HS-1:0] hs_flag_nxt;
	logic [NUM_HS-1:0] hs_trip_nxt;
	logic [NUM_HS-1:0] hs_gate_nxt;
	logic [NUM_HS-1:0] hs_on;
	logic [NUM_HS-1:0] hs_pwm;
	logic [NUM_HB-1:0] hb_flag;
	logic [NUM_HB-1:0] hb_hs;
	logic [NUM_HB-1:0] hb_ls;
	logic              aux_off_r;
	logic              hot_irq_r;
	logic              aw_full_r;
	logic              w_full_r;
	logic [IDX_W-1:0]  aw_idx_r;
	logic              aw_bad_r;
	logic [7:0]        wdata_r;
	logic              wstrb0_r;
	logic              bvalid_r;
	logic [1:0]        bresp_r;
	logic              rvalid_r;
	logic [31:0]       rdata_r;
	logic [1:0]        rresp_r;
	logic              aw_take;
	logic              w_take;
	logic              wr_go;
	logic              wr_en;
	logic              ar_take;
	logic [IDX_W-1:0]  ar_idx;
	logic              ar_bad;
	logic [7:0]        rd_byte;
	logic [7:0]        wd;
	logic              hot_sd_en;
	logic              hot_block;
	logic              hot2_off;
	logic              volt_block;
	logic              stage_en;
	logic              hb_block;
	logic              hs_kill;
	logic              clr_hot;
	logic              clr_uv;
	logic              clr_ov;
	logic [NUM_HB-1:0] clr_hb;
	logic [NUM_HS-1:0] clr_hs;
	logic              hot_nxt;

	function automatic logic idx_bad(input logic [ADDR_W-1:0] a);
		logic [IDX_W-1:0] i;
		i = a[IDX_LSB +: IDX_W];
		idx_bad = (a[ADDR_W-1:IDX_LSB+IDX_W] != '0) ||
			!(i == IDX_SYS_CTRL || i == IDX_BRIDGE_SEL || i == IDX_HS_OUT ||
			i == IDX_BRIDGE_STAT || i == IDX_HS_STAT || i == IDX_IRQ_FLAG ||
			i == IDX_IRQ_MASK || i == IDX_AMUX);
	endfunction

	// ==============================
	// Pin synchronisers
	psp_sync2 #(.W($bits(psp_sense_t))) u_sync (
		.clk (clk),
		.rst (rst),
		.d   (sense_in),
		.q   (s)
	);

	// Edge seen once per rise, re-arms tripped PWM-only high side drivers
	assign pwm_rise = s.pwm & ~pwm_d_r;

	// ==============================
	// Bus write side
	assign aw_take = bus_req.awvalid & ~aw_full_r;
	assign w_take  = bus_req.wvalid & ~w_full_r;
	assign wr_go   = aw_full_r & w_full_r & ~bvalid_r;
	assign wr_en   = wr_go & ~aw_bad_r & wstrb0_r;
	assign wd      = wdata_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_full_r <= 1'h0;
			w_full_r  <= 1'h0;
			aw_idx_r  <= '0;
			aw_bad_r  <= 1'h0;
			wdata_r   <= 8'h00;
			wstrb0_r  <= 1'h0;
			bvalid_r  <= 1'h0;
			bresp_r   <= RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_full_r <= 1'h1;
				aw_idx_r  <= bus_req.awaddr[IDX_LSB +: IDX_W];
				aw_bad_r  <= idx_bad(bus_req.awaddr);
			end else if (wr_go) begin
				aw_full_r <= 1'h0;
			end
			if (w_take) begin
				w_full_r <= 1'h1;
				wdata_r  <= bus_req.wdata[7:0];
				wstrb0_r <= bus_req.wstrb[0];
			end else if (wr_go) begin
				w_full_r <= 1'h0;
			end
			if (wr_go) begin
				bvalid_r <= 1'h1;
				bresp_r  <= aw_bad_r ? RESP_SLVERR : RESP_OKAY;
			end else if (bus_req.bready) begin
				bvalid_r <= 1'h0;
			end
		end
	end

	// ==============================
	// Write-one-to-clear strobes
	assign clr_hot = wr_en & (aw_idx_r == IDX_IRQ_FLAG) & wd[IRQ_HOT];
	assign clr_uv  = wr_en & (aw_idx_r == IDX_IRQ_FLAG) & wd[IRQ_UV];
	assign clr_ov  = wr_en & (aw_idx_r == IDX_IRQ_FLAG) & wd[IRQ_OV];
	assign clr_hb  = {NUM_HB{wr_en & (aw_idx_r == IDX_BRIDGE_STAT)}} & wd[NUM_HB-1:0];
	assign clr_hs  = {NUM_HS{wr_en & (aw_idx_r == IDX_HS_STAT)}} & wd[NUM_HS-1:0];

	// ==============================
	// Control registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sys_r      <= 4'h0;
			bsel_r     <= 8'h00;
			hso_r      <= 6'h00;
			recirc_r   <= 1'h0;
			hot_mask_r <= 1'h0;
			gain_r     <= 1'h0;
		end else if (wr_en) begin
			if (aw_idx_r == IDX_SYS_CTRL)
				sys_r <= wd[3:0];
			if (aw_idx_r == IDX_BRIDGE_SEL)
				bsel_r <= wd;
			if (aw_idx_r == IDX_HS_OUT)
				hso_r <= wd[5:0];
			if (aw_idx_r == IDX_BRIDGE_STAT)
				recirc_r <= wd[BST_RECIRC];
			if (aw_idx_r == IDX_IRQ_MASK)
				hot_mask_r <= wd[IRQ_HOT];
			if (aw_idx_r == IDX_AMUX)
				gain_r <= wd[AMUX_GAIN];
		end
	end

	// ==============================
	// Protection terms
	assign stage_en   = sys_r[SYS_STG_EN];
	assign hot_sd_en  = |sys_r[SYS_HOT_SD +: 2];
	assign hot_block  = hot_flag_r & hot_sd_en;
	assign hot2_off   = s.temp_reset & ~hot_sd_en;
	assign volt_block = (uv_r | ov_r) & ~sys_r[SYS_V_INH];
	assign hb_block   = volt_block | hot2_off | ~stage_en;
	assign hs_kill    = volt_block | hot2_off | ~stage_en | hot_block;
	// Condition still present re-sets the flag, so a clear cannot win
	assign hot_nxt    = s.temp_hot | (hot_flag_r & ~clr_hot);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hot_flag_r <= 1'h0;
			uv_r       <= 1'h0;
			ov_r       <= 1'h0;
			pwm_d_r    <= 1'h0;
			aux_off_r  <= 1'h0;
			hot_irq_r  <= 1'h0;
		end else begin
			hot_flag_r <= hot_nxt;
			uv_r       <= s.low_volt | (uv_r & ~clr_uv);
			ov_r       <= s.high_volt | (ov_r & ~clr_ov);
			pwm_d_r    <= s.pwm;
			aux_off_r  <= hot2_off;
			hot_irq_r  <= hot_flag_r & hot_mask_r;
		end
	end

	// ==============================
	// Half-bridges
	for (genvar b = 0; b < NUM_HB; b++) begin : g_hb
		psp_hb_leg u_leg (
			.clk       (clk),
			.rst       (rst),
			.sel_l     (bsel_r[2*b]),
			.sel_h     (bsel_r[2*b+1]),
			.recirc    (recirc_r),
			.pwm       (s.pwm),
			.flag_clr  (clr_hb[b]),
			.hs_block  (hot_block),
			.all_block (hb_block),
			.oc_hs     (s.hb_oc_hs[b]),
			.oc_ls     (s.hb_oc_ls[b]),
			.flag_r    (hb_flag[b]),
			.hs_gate_r (hb_hs[b]),
			.ls_gate_r (hb_ls[b])
		);
	end

	// ==============================
	// High sides
	assign hs_on  = hso_r[NUM_HS-1:0];
	assign hs_pwm = hso_r[HSO_PWM +: NUM_HS];
	for (genvar h = 0; h < NUM_HS; h++) begin : g_hs
		logic trip_set;
		logic want;
		// On-only and PWM-only modes trip; both set only flags the limit
		assign trip_set = s.hs_oc[h] & (hs_on[h] ^ hs_pwm[h]);
		assign hs_flag_nxt[h] = (s.hs_oc[h] & (hs_on[h] | hs_pwm[h])) |
			(hs_flag_r[h] & ~clr_hs[h]);
		assign hs_trip_nxt[h] = trip_set | (hs_trip_r[h] & ~clr_hs[h] &
			~(pwm_rise & hs_pwm[h] & ~hs_on[h]));
		assign want = (hs_pwm[h] & ~hs_on[h]) ? s.pwm : hs_on[h];
		assign hs_gate_nxt[h] = want & ~hs_trip_nxt[h] & ~hs_kill;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hs_flag_r <= '0;
			hs_trip_r <= '0;
			hs_gate_r <= '0;
		end else begin
			hs_flag_r <= hs_flag_nxt;
			hs_trip_r <= hs_trip_nxt;
			hs_gate_r <= hs_gate_nxt;
		end
	end

	// ==============================
	// Bus read side, reads have no side effects
	assign ar_take = bus_req.arvalid & ~rvalid_r;
	assign ar_idx  = bus_req.araddr[IDX_LSB +: IDX_W];
	assign ar_bad  = idx_bad(bus_req.araddr);
	assign rd_byte =
		(ar_idx == IDX_SYS_CTRL)    ? {4'h0, sys_r} :
		(ar_idx == IDX_BRIDGE_SEL)  ? bsel_r :
		(ar_idx == IDX_HS_OUT)      ? {2'h0, hso_r} :
		(ar_idx == IDX_BRIDGE_STAT) ? {recirc_r, 3'h0, hb_flag} :
		(ar_idx == IDX_HS_STAT)     ? {5'h00, hs_flag_r} :
		(ar_idx == IDX_IRQ_FLAG)    ? {5'h00, ov_r, uv_r, hot_flag_r} :
		(ar_idx == IDX_IRQ_MASK)    ? {7'h00, hot_mask_r} :
		(ar_idx == IDX_AMUX)        ? {7'h00, gain_r} : 8'h00;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rvalid_r <= 1'h0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= RESP_OKAY;
		end else if (ar_take) begin
			rvalid_r <= 1'h1;
			rdata_r  <= {24'h00_0000, ar_bad ? 8'h00 : rd_byte};
			rresp_r  <= ar_bad ? RESP_SLVERR : RESP_OKAY;
		end else if (bus_req.rready) begin
			rvalid_r <= 1'h0;
		end
	end

	// ==============================
	// Outputs
	assign bus_rsp.awready  = ~aw_full_r;
	assign bus_rsp.wready   = ~w_full_r;
	assign bus_rsp.bvalid   = bvalid_r;
	assign bus_rsp.bresp    = bresp_r;
	assign bus_rsp.arready  = ~rvalid_r;
	assign bus_rsp.rvalid   = rvalid_r;
	assign bus_rsp.rdata    = rdata_r;
	assign bus_rsp.rresp    = rresp_r;
	assign gate_out.hb_hs   = hb_hs;
	assign gate_out.hb_ls   = hb_ls;
	assign gate_out.hs      = hs_gate_r;
	assign gate_out.aux_off = aux_off_r;
	assign hot_irq          = hot_irq_r;
	assign sense_gain_low   = gain_r;

	// ==============================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence hs_tripped_pwm(int h);
		hs_pwm[h] && !hs_on[h] && hs_trip_r[h];
	endsequence

	a_hot_flag_set: assert property (
		s.temp_hot |=> hot_flag_r ##1 (hot_irq == hot_mask_r))
		else $error("hot flag or interrupt wrong");
	a_hot_clear_hold: assert property (
		s.temp_hot && clr_hot |=> hot_flag_r)
		else $error("hot flag cleared during condition");
	a_hot_hs_off: assert property (
		hot_flag_r && hot_sd_en |=> hs_gate_r == '0 && hb_hs == '0)
		else $error("high side on during hot shutdown");
	a_hot2_all_off: assert property (
		s.temp_reset && !hot_sd_en |=> aux_off_r && hb_hs == '0 && hb_ls == '0
		&& hs_gate_r == '0)
		else $error("stage on above second threshold");
	a_volt_block: assert property (
		(uv_r || ov_r) && !sys_r[SYS_V_INH] |=> hb_hs == '0 && hb_ls == '0
		&& hs_gate_r == '0)
		else $error("outputs on during voltage fault");
	a_volt_hold: assert property (
		s.low_volt && uv_r |=> uv_r)
		else $error("undervoltage flag lost while present");
	a_stage_gate: assert property (
		!stage_en |=> hs_gate_r == '0 && hb_hs == '0 && hb_ls == '0)
		else $error("high side on with stages off");
	a_hs_pwm_follow: assert property (
		hs_pwm[0] && !hs_on[0] && !hs_trip_nxt[0] && !hs_kill
		|=> hs_gate_r[0] == $past(s.pwm))
		else $error("pwm high side not following input");
	a_hs_rearm: assert property (
		hs_tripped_pwm(0) ##0 pwm_rise && !s.hs_oc[0] |=> !hs_trip_r[0])
		else $error("rising edge did not re-arm driver");
	a_hs_limit: assert property (
		hs_on[0] && hs_pwm[0] && s.hs_oc[0] && !hs_kill
		|=> hs_flag_r[0] && hs_gate_r[0])
		else $error("current limit disabled output");
	a_hs_on_trip: assert property (
		hs_on[0] && !hs_pwm[0] && s.hs_oc[0] |=> hs_flag_r[0] && !hs_gate_r[0])
		else $error("on mode over-current not handled");
	a_bus_bresp: assert property (
		wr_go |=> bvalid_r)
		else $error("write without response");
endmodule
`default_nettype wire

// ---- psp_drv_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module psp_drv_model import psp_pkg::*; (
	// Clock
	input  wire logic              clk,
	// Gate commands and injected shorts
	input  wire psp_gate_t         gate,
	input  wire logic [NUM_HB-1:0] sh_hs,
	input  wire logic [NUM_HB-1:0] sh_ls,
	input  wire logic [NUM_HS-1:0] sh_hx,
	input  wire logic [4:0]        env,
	// Comparator outputs
	output var  psp_sense_t        sense
);
	// ==============================
	// Comparators
	// Over-current only shows while the transistor conducts into a short
	always_ff @(posedge clk) begin
		sense.hb_oc_hs <= gate.hb_hs & sh_hs;
		sense.hb_oc_ls <= gate.hb_ls & sh_ls;
		sense.hs_oc <= gate.hs & sh_hx;
		sense.temp_hot <= env[4];
		sense.temp_reset <= env[3];
		sense.low_volt <= env[2];
		sense.high_volt <= env[1];
		sense.pwm <= env[0];
	end
endmodule
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench import psp_pkg::*;;
	// ==============================
	// Signals
	localparam int E_HOT = 4;
	localparam int E_RST = 3;
	localparam int E_LV  = 2;
	localparam int E_HV  = 1;
	localparam int E_PWM = 0;
	logic          clk;
	logic          rst;
	psp_axil_req_t req;
	psp_axil_rsp_t rsp;
	psp_sense_t    sense;
	psp_gate_t     gate;
	logic          hot_irq;
	logic          gain_low;
	logic [3:0]    sh_hs;
	logic [3:0]    sh_ls;
	logic [2:0]    sh_hx;
	logic [4:0]    env;
	logic [1:0]    resp;
	logic [31:0]   rdv;
	int            n_errors;
	int            n_checks;

	psp_ctrl i_psp_ctrl (.clk(clk), .rst(rst), .bus_req(req), .bus_rsp(rsp),
		.sense_in(sense), .gate_out(gate), .hot_irq(hot_irq), .sense_gain_low(gain_low));
	psp_drv_model i_psp_drv_model (.clk(clk), .gate(gate), .sh_hs(sh_hs), .sh_ls(sh_ls),
		.sh_hx(sh_hx), .env(env), .sense(sense));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ==============================
	// Checking
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_gate(input psp_gate_t exp);
		n_checks++;
		if (gate !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t gates %h expected %h", $time, gate, exp);
		end
	endtask

	function automatic psp_gate_t g(input logic [3:0] h, input logic [3:0] l,
		input logic [2:0] s, input logic a);
		g.hb_hs = h;
		g.hb_ls = l;
		g.hs = s;
		g.aux_off = a;
	endfunction

	// Gates are not handshaken: give synchroniser and model time to land
	task automatic settle;
		repeat (8) @(posedge clk);
	endtask

	// ==============================
	// Bus master
	task automatic wr(input logic [3:0] idx, input logic [7:0] d);
		int n;
		logic a, w, b;
		@(posedge clk);
		req.awvalid <= 1'b1;
		req.awaddr <= {2'h0, idx, 2'h0};
		req.wvalid <= 1'b1;
		req.wdata <= {24'h0, d};
		req.wstrb <= 4'hF;
		req.bready <= 1'b1;
		b = 1'b0;
		n = 0;
		while (!b && n < 200) begin
			@(negedge clk);
			a = req.awvalid & rsp.awready;
			w = req.wvalid & rsp.wready;
			b = rsp.bvalid;
			resp = rsp.bresp;
			@(posedge clk);
			if (a) req.awvalid <= 1'b0;
			if (w) req.wvalid <= 1'b0;
			if (b) req.bready <= 1'b0;
			n++;
		end
		if (!b) begin
			n_errors++;
			$display("MISMATCH t=%0t write got no response", $time);
		end
	endtask

	task automatic rd(input logic [3:0] idx);
		int n;
		logic a, r;
		@(posedge clk);
		req.arvalid <= 1'b1;
		req.araddr <= {2'h0, idx, 2'h0};
		req.rready <= 1'b1;
		r = 1'b0;
		n = 0;
		while (!r && n < 200) begin
			@(negedge clk);
			a = req.arvalid & rsp.arready;
			r = rsp.rvalid;
			rdv = rsp.rdata;
			resp = rsp.rresp;
			@(posedge clk);
			if (a) req.arvalid <= 1'b0;
			if (r) req.rready <= 1'b0;
			n++;
		end
		if (!r) begin
			n_errors++;
			$display("MISMATCH t=%0t read got no response", $time);
		end
	endtask

	task automatic rdc(input logic [3:0] idx, input logic [7:0] e);
		rd(idx);
		chk_reg(rdv, {24'h0, e});
		chk_reg({30'h0, resp}, {30'h0, RESP_OKAY});
	endtask

	// ==============================
	// Scenarios
	task automatic t_reset;
		chk_gate(g(4'h0, 4'h0, 3'h0, 1'b0));
		rdc(IDX_BRIDGE_STAT, 8'h00);
		wr(4'hF, 8'h01);
		chk_reg({30'h0, resp}, {30'h0, RESP_SLVERR});
		rd(4'hF);
		chk_reg({30'h0, resp}, {30'h0, RESP_SLVERR});
	endtask

	task automatic t_hs;
		wr(IDX_SYS_CTRL, 8'h01);
		wr(IDX_HS_OUT, 8'h07);
		settle;
		chk_gate(g(4'h0, 4'h0, 3'h7, 1'b0));
		wr(IDX_SYS_CTRL, 8'h00);
		settle;
		chk_gate(g(4'h0, 4'h0, 3'h0, 1'b0));
		wr(IDX_SYS_CTRL, 8'h01);
		sh_hx <= 3'h1;
		settle;
		sh_hx <= 3'h0;
		settle;
		chk_gate(g(4'h0, 4'h0, 3'h6, 1'b0));
		rdc(IDX_HS_STAT, 8'h01);
		wr(IDX_HS_STAT, 8'h00);
		rdc(IDX_HS_STAT, 8'h01);
		wr(IDX_HS_STAT, 8'h01);
		settle;
		chk_gate(g(4'h0, 4'h0, 3'h7, 1'b0));
		rdc(IDX_HS_STAT, 8'h00);
	endtask

	task automatic t_hspwm;
		wr(IDX_HS_OUT, 8'h08);
		env[E_PWM] <= 1'b1;
		settle;
		chk_gate(g(4'h0, 4'h0, 3'h1, 1'b0));
		env[E_PWM] <= 1'b0;
		settle;
		chk_gate(g(4'h0, 4'h0, 3'h0, 1'b0));
		env[E_PWM] <= 1'b1;
		sh_hx <= 3'h1;
		settle;
		sh_hx <= 3'h0;
		settle;
		chk_gate(g(4'h0, 4'h0, 3'h0, 1'b0));
		rdc(IDX_HS_STAT, 8'h01);
		env[E_PWM] <= 1'b0;
		settle;
		env[E_PWM] <= 1'b1;
		settle;
		chk_gate(g(4'h0, 4'h0, 3'h1, 1'b0));
		wr(IDX_HS_STAT, 8'h01);
		wr(IDX_HS_OUT, 8'h09);
		env[E_PWM] <= 1'b0;
		sh_hx <= 3'h1;
		settle;
		chk_gate(g(4'h0, 4'h0, 3'h1, 1'b0));
		rdc(IDX_HS_STAT, 8'h01);
		sh_hx <= 3'h0;
		settle;
		wr(IDX_HS_STAT, 8'h01);
		rdc(IDX_HS_STAT, 8'h00);
		wr(IDX_HS_OUT, 8'h00);
	endtask

	task automatic t_bridge;
		wr(IDX_BRIDGE_SEL, 8'h02);
		sh_hs <= 4'h1;
		settle;
		sh_hs <= 4'h0;
		settle;
		chk_gate(g(4'h0, 4'h0, 3'h0, 1'b0));
		rdc(IDX_BRIDGE_STAT, 8'h01);
		wr(IDX_BRIDGE_STAT, 8'h00);
		rdc(IDX_BRIDGE_STAT, 8'h01);
		wr(IDX_BRIDGE_STAT, 8'h01);
		settle;
		chk_gate(g(4'h1, 4'h0, 3'h0, 1'b0));
		rdc(IDX_BRIDGE_STAT, 8'h00);
		wr(IDX_BRIDGE_SEL, 8'h01);
		sh_ls <= 4'h1;
		settle;
		sh_ls <= 4'h0;
		settle;
		chk_gate(g(4'h0, 4'h0, 3'h0, 1'b0));
		rdc(IDX_BRIDGE_STAT, 8'h01);
		wr(IDX_BRIDGE_STAT, 8'h01);
	endtask

	task automatic t_pwmhb;
		wr(IDX_BRIDGE_SEL, 8'h0C);
		wr(IDX_BRIDGE_STAT, 8'h80);
		env[E_PWM] <= 1'b1;
		settle;
		chk_gate(g(4'h2, 4'h0, 3'h0, 1'b0));
		env[E_PWM] <= 1'b0;
		settle;
		chk_gate(g(4'h0, 4'h2, 3'h0, 1'b0));
		rdc(IDX_BRIDGE_STAT, 8'h80);
		wr(IDX_BRIDGE_STAT, 8'h00);
		settle;
		chk_gate(g(4'h0, 4'h0, 3'h0, 1'b0));
	endtask

	task automatic t_volt;
		wr(IDX_BRIDGE_SEL, 8'h02);
		wr(IDX_HS_OUT, 8'h01);
		env[E_LV] <= 1'b1;
		settle;
		chk_gate(g(4'h0, 4'h0, 3'h0, 1'b0));
		wr(IDX_IRQ_FLAG, 8'h02);
		rdc(IDX_IRQ_FLAG, 8'h02);
		env[E_LV] <= 1'b0;
		settle;
		chk_gate(g(4'h0, 4'h0, 3'h0, 1'b0));
		wr(IDX_IRQ_FLAG, 8'h02);
		settle;
		chk_gate(g(4'h1, 4'h0, 3'h1, 1'b0));
		wr(IDX_SYS_CTRL, 8'h03);
		env[E_HV] <= 1'b1;
		settle;
		chk_gate(g(4'h1, 4'h0, 3'h1, 1'b0));
		rdc(IDX_IRQ_FLAG, 8'h04);
		env[E_HV] <= 1'b0;
		settle;
		wr(IDX_IRQ_FLAG, 8'h04);
		rdc(IDX_IRQ_FLAG, 8'h00);
		wr(IDX_SYS_CTRL, 8'h01);
	endtask

	task automatic t_hot;
		wr(IDX_IRQ_MASK, 8'h01);
		wr(IDX_SYS_CTRL, 8'h05);
		wr(IDX_BRIDGE_SEL, 8'h06);
		env[E_HOT] <= 1'b1;
		settle;
		chk_gate(g(4'h0, 4'h2, 3'h0, 1'b0));
		chk_reg({31'h0, hot_irq}, 32'h1);
		wr(IDX_IRQ_FLAG, 8'h01);
		rdc(IDX_IRQ_FLAG, 8'h01);
		env[E_HOT] <= 1'b0;
		settle;
		wr(IDX_IRQ_FLAG, 8'h01);
		settle;
		chk_gate(g(4'h1, 4'h2, 3'h1, 1'b0));
		chk_reg({31'h0, hot_irq}, 32'h0);
		wr(IDX_IRQ_MASK, 8'h00);
		wr(IDX_SYS_CTRL, 8'h01);
		env[E_HOT] <= 1'b1;
		settle;
		chk_gate(g(4'h1, 4'h2, 3'h1, 1'b0));
		chk_reg({31'h0, hot_irq}, 32'h0);
		rdc(IDX_IRQ_FLAG, 8'h01);
		env[E_HOT] <= 1'b0;
		env[E_RST] <= 1'b1;
		settle;
		chk_gate(g(4'h0, 4'h0, 3'h0, 1'b1));
		wr(IDX_IRQ_FLAG, 8'h01);
		env[E_RST] <= 1'b0;
	endtask

	task automatic t_gain;
		wr(IDX_AMUX, 8'h01);
		settle;
		chk_reg({31'h0, gain_low}, 32'h1);
		wr(IDX_AMUX, 8'h00);
		settle;
		chk_reg({31'h0, gain_low}, 32'h0);
	endtask

	// ==============================
	// Run control
	task automatic wrap_up;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		n_errors = 0;
		n_checks = 0;
		rst = 1'b1;
		req = '0;
		sh_hs = 4'h0;
		sh_ls = 4'h0;
		sh_hx = 3'h0;
		env = 5'h00;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_hs;
		t_hspwm;
		t_bridge;
		t_pwmhb;
		t_volt;
		t_hot;
		t_gain;
		wrap_up;
	end

	// Whole run is well under a thousand cycles; this is far beyond it
	initial begin
		#100us;
		n_errors++;
		wrap_up;
	end
endmodule
`default_nettype wire
